// >>> bench/fpec_cpu_model.sv
// core side: one access at a time, held until the wait request drops
module fpec_cpu_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic go_we,
  input  wire logic go_fl,
  input  wire logic cpu_wait,
  output logic      cpu_req,
  output logic      cpu_we,
  output logic      cpu_in_flash,
  output int        waits
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge clock) begin
    if (rst) begin
      cpu_req      <= 1'b0;
      cpu_we       <= 1'b0;
      cpu_in_flash <= 1'b0;
      waits        <= 0;
    end else if (!cpu_req && go) begin
      cpu_req      <= 1'b1;
      cpu_we       <= go_we;
      cpu_in_flash <= go_fl;
      waits        <= 0;
    end else if (cpu_req && cpu_wait) begin
      waits <= waits + 1;
    end else if (cpu_req) begin
      // released lines flip so a stale value never looks qualified
      cpu_req      <= 1'b0;
      cpu_we       <= ~cpu_we;
      cpu_in_flash <= ~cpu_in_flash;
    end
  end
endmodule // fpec_cpu_model

// >>> bench/fpec_top_test.sv
`include "fpec_regs.svh"

module fpec_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, io_flash_wr = 0, go = 0, go_we = 0, go_fl = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, io_flash_data = 0, reg_rdata, prog_data, d;
  logic [6:0] prog_col, erase_page_sel;
  logic       cpu_req, cpu_we, cpu_in_flash, cpu_wait, prog_wr, erase_mass, erase_page, irq;
  int         cpu_waits, fail_count = 0, cmp_count = 0, cycles = 0, seed = 29, ecount = 0;

  always #4 clock = ~clock;

  // short counts keep erase and timeout runs to a few dozen cycles
  fpec_top #(.MASS_CYC(20), .PAGE_CYC(10), .ROW_TMO_CYC(40)) i_fpec_top (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_flash_wr(io_flash_wr), .io_flash_data(io_flash_data),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_in_flash(cpu_in_flash), .cpu_wait(cpu_wait),
    .prog_wr(prog_wr), .prog_col(prog_col), .prog_data(prog_data), .erase_mass(erase_mass),
    .erase_page(erase_page), .erase_page_sel(erase_page_sel), .irq(irq));

  fpec_cpu_model i_fpec_cpu_model (.clock(clock), .rst(rst), .go(go), .go_we(go_we), .go_fl(go_fl),
    .cpu_wait(cpu_wait), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_in_flash(cpu_in_flash), .waits(cpu_waits));

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (erase_mass || erase_page)
      ecount <= ecount + 1;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict;
    end
  end

  function automatic logic [7:0] col_exp(input logic [7:0] v);
    return {1'b0, v[6:0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (e !== g) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  task automatic iow(input logic [7:0] v, input logic [6:0] c);
    @(posedge clock);
    io_flash_wr   <= 1'b1;
    io_flash_data <= v;
    @(posedge clock);
    io_flash_wr <= 1'b0;
    #1 chk("prog_wr", 1'b1, prog_wr);
    chk("prog_col", c, prog_col);
    chk("prog_data", v, prog_data);
  endtask

  task automatic cpu(input logic we, input logic fl);
    @(posedge clock);
    go    <= 1'b1;
    go_we <= we;
    go_fl <= fl;
    @(posedge clock);
    go <= 1'b0;
  endtask

  // b selects the control bit: 0 page erase, 1 mass erase
  task automatic erase_run(input int b, input int len);
    logic [7:0] pg;
    pg = $random(seed) & 8'h7f;
    wr(`FPEC_OFF_PAGE, pg);
    ecount = 0;
    wr(`FPEC_OFF_CTL, 8'h01 << b);
    #1 chk("erase_on", 1'b1, b ? erase_mass : erase_page);
    if (b == 0) chk("page_sel", pg, {1'b0, erase_page_sel});
    cpu(1'b1, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk("outside_wait", 1'b0, cpu_req || cpu_waits != 0);
    cpu(b[0], 1'b1);
    repeat (len + 4) @(posedge clock);
    #1 chk("erase_len", 1'b1, ecount >= len && ecount <= len + 2);
    chk("flash_wait", 1'b1, !cpu_req && cpu_waits > 3);
    rd(`FPEC_OFF_CTL, 8'h00, "ctl_clear");
    rd(`FPEC_OFF_STAT, 8'h01, "stat_done");
    wr(`FPEC_OFF_MASK, 8'h01);
    #1 chk("irq_set", 1'b1, irq);
    wr(`FPEC_OFF_STAT, 8'h01);
    #1 chk("irq_clr", 1'b0, irq);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(`FPEC_OFF_COL, 8'h00, "col_reset");
    rd(8'h10, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : $random(seed);
      wr(`FPEC_OFF_COL, d);
      rd(`FPEC_OFF_COL, col_exp(d), "col_rw");
      iow($random(seed), d[6:0]);
    end
    erase_run(0, 10);
    erase_run(1, 20);
    wr(`FPEC_OFF_COL, 8'h7d);
    wr(`FPEC_OFF_CTL, 8'h04);
    cpu(1'b0, 1'b1);
    for (int k = 0; k < 3; k++)
      iow($random(seed), 7'h7d + k);
    repeat (3) @(posedge clock);
    #1 chk("row_read_wait", 1'b1, !cpu_req && cpu_waits > 0);
    rd(`FPEC_OFF_STAT, 8'h02, "row_done");
    wr(`FPEC_OFF_STAT, 8'h07);
    wr(`FPEC_OFF_COL, 8'h00);
    wr(`FPEC_OFF_CTL, 8'h04);
    cpu(1'b0, 1'b1);
    repeat (50) @(posedge clock);
    #1 chk("tmo_wait", 1'b1, !cpu_req && cpu_waits > 30);
    rd(`FPEC_OFF_STAT, 8'h04, "row_tmo");
    give_verdict;
  end
endmodule // fpec_top_test

// >>> design/fpec_pkg.sv
package fpec_pkg;
  `include "fpec_regs.svh"

  typedef enum logic [1:0] {
    FPEC_IDLE,
    FPEC_MASS,
    FPEC_PAGE,
    FPEC_ROW
  } fpec_state_e;

  typedef logic [`FPEC_TMR_W-1:0] fpec_count_t;
endpackage

// >>> design/fpec_regs.svh
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// register offsets on the plain register port
`define FPEC_OFF_PAGE     8'hfb
`define FPEC_OFF_STAT     8'hfc
`define FPEC_OFF_MASK     8'hfd
`define FPEC_OFF_COL      8'hfe
`define FPEC_OFF_CTL      8'hff

// program control bits
`define FPEC_CTL_PAGE     0
`define FPEC_CTL_MASS     1
`define FPEC_CTL_ROW      2

// status / mask bits
`define FPEC_ST_ERASE     0
`define FPEC_ST_ROW       1
`define FPEC_ST_TMO       2
`define FPEC_ST_W         3

// widths and reset values
`define FPEC_COL_W        7
`define FPEC_COL_LAST     7'h7f
`define FPEC_COL_RST      7'h00
`define FPEC_PAGE_W       7
`define FPEC_TMR_W        25

// timing, times in ms, clock in kHz
`define FPEC_CLK_KHZ      125000
`define FPEC_MASS_MS      200
`define FPEC_PAGE_MS      10
`define FPEC_ROW_TMO_MS   1

`endif

// >>> design/fpec_timer.sv
module fpec_timer
  import fpec_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  fpec_tmr_if.tmr   t
);
  fpec_count_t cnt_r;
  logic        busy_r;
  logic        done_r;

  assign t.busy = busy_r;
  assign t.done = done_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (t.stop) begin
        busy_r <= 1'b0;
      end else if (t.start) begin
        cnt_r  <= t.len;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= fpec_count_t'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - fpec_count_t'(1);
        end
      end
    end
  end
endmodule // fpec_timer

// >>> design/fpec_tmr_if.sv
interface fpec_tmr_if;
  import fpec_pkg::*;
  logic        start;
  logic        stop;
  fpec_count_t len;
  logic        busy;
  logic        done;

  modport ctl (output start, output stop, output len, input busy, input done);
  modport tmr (input start, input stop, input len, output busy, output done);
endinterface

// >>> design/fpec_top.sv
`include "fpec_regs.svh"

// Summary of operation
// R1: column select holds a 7-bit value picking one of 128 bytes in a row
// R2: a flash I/O write outside row programming uses the column select as its byte position
// R3: row programming loads the column incrementer from column select
// R4: column bits 6:0 read-write, bit 7 reserved reads zero, reset zero
// R5: control offers mass erase, page erase and row programming
// R6: erase bits clear themselves when the erase finishes
// R7: mass erase clears whole flash and info page, about 200 ms
// R8: page erase clears one 1 KB page, about 10 ms
// R9: flash reads and writes wait while any erase runs
// R10: accesses outside flash never wait during erase
// R11: flash reads wait during row programming until done or timeout
// R12: incrementer steps one column per byte, staying inside the row
module fpec_top
  import fpec_pkg::*;
#(
  parameter int unsigned MASS_CYC = `FPEC_MASS_MS * `FPEC_CLK_KHZ,
  parameter int unsigned PAGE_CYC = `FPEC_PAGE_MS * `FPEC_CLK_KHZ,
  parameter int unsigned ROW_TMO_CYC = `FPEC_ROW_TMO_MS * `FPEC_CLK_KHZ
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    io_flash_wr,
  input  wire logic [7:0]              io_flash_data,
  input  wire logic                    cpu_req,
  input  wire logic                    cpu_we,
  input  wire logic                    cpu_in_flash,
  output logic                         cpu_wait,
  output logic                         prog_wr,
  output logic [`FPEC_COL_W-1:0]       prog_col,
  output logic [7:0]                   prog_data,
  output logic                         erase_mass,
  output logic                         erase_page,
  output logic [`FPEC_PAGE_W-1:0]      erase_page_sel,
  output logic                         irq
);
  fpec_state_e                 state_r;
  logic [`FPEC_COL_W-1:0]      col_r;
  logic [`FPEC_COL_W-1:0]      inc_r;
  logic [`FPEC_PAGE_W-1:0]     page_r;
  logic [`FPEC_ST_W-1:0]       stat_r;
  logic [`FPEC_ST_W-1:0]       mask_r;
  logic [`FPEC_ST_W-1:0]       ev;
  logic [7:0]                  ctl_view;
  logic                        wr_col;
  logic                        wr_ctl;
  logic                        row_last;

  fpec_tmr_if tif ();

  fpec_timer u_timer (
    .clock (clock),
    .rst   (rst),
    .t     (tif.tmr)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr_col   = reg_wr && hit(reg_addr, `FPEC_OFF_COL);
  assign wr_ctl   = reg_wr && hit(reg_addr, `FPEC_OFF_CTL) && state_r == FPEC_IDLE;
  assign row_last = state_r == FPEC_ROW && io_flash_wr && inc_r == `FPEC_COL_LAST;

  // column select register
  always_ff @(posedge clock) begin
    if (rst) begin
      col_r <= `FPEC_COL_RST; // [R4]
    end else if (wr_col) begin
      col_r <= reg_wdata[`FPEC_COL_W-1:0]; // [R1] [R4]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      page_r <= '0;
    end else if (reg_wr && hit(reg_addr, `FPEC_OFF_PAGE) && state_r == FPEC_IDLE) begin
      page_r <= reg_wdata[`FPEC_PAGE_W-1:0];
    end
  end

  // operation sequencer; control writes while busy are dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= FPEC_IDLE;
    end else begin
      case (state_r)
        FPEC_IDLE: begin
          if (wr_ctl && reg_wdata[`FPEC_CTL_MASS]) begin
            state_r <= FPEC_MASS; // [R5]
          end else if (wr_ctl && reg_wdata[`FPEC_CTL_PAGE]) begin
            state_r <= FPEC_PAGE; // [R5]
          end else if (wr_ctl && reg_wdata[`FPEC_CTL_ROW]) begin
            state_r <= FPEC_ROW; // [R5]
          end
        end
        FPEC_MASS, FPEC_PAGE: begin
          if (tif.done) begin
            state_r <= FPEC_IDLE; // [R6]
          end
        end
        FPEC_ROW: begin
          if (tif.done || row_last) begin
            state_r <= FPEC_IDLE; // [R11]
          end
        end
        default: state_r <= FPEC_IDLE;
      endcase
    end
  end

  // timer launch: length picked by the requested operation
  always_comb begin
    tif.start = wr_ctl && (reg_wdata[`FPEC_CTL_MASS] || reg_wdata[`FPEC_CTL_PAGE] || reg_wdata[`FPEC_CTL_ROW]);
    tif.stop  = row_last;
    if (reg_wdata[`FPEC_CTL_MASS]) begin
      tif.len = fpec_count_t'(MASS_CYC); // [R7]
    end else if (reg_wdata[`FPEC_CTL_PAGE]) begin
      tif.len = fpec_count_t'(PAGE_CYC); // [R8]
    end else begin
      tif.len = fpec_count_t'(ROW_TMO_CYC);
    end
  end

  // incrementer; wraps inside the row so a row never spills into the next
  always_ff @(posedge clock) begin
    if (rst) begin
      inc_r <= `FPEC_COL_RST;
    end else if (wr_ctl && reg_wdata[`FPEC_CTL_ROW] && !reg_wdata[`FPEC_CTL_MASS]
                 && !reg_wdata[`FPEC_CTL_PAGE]) begin
      inc_r <= col_r; // [R3]
    end else if (state_r == FPEC_ROW && io_flash_wr) begin
      inc_r <= inc_r + `FPEC_COL_W'(1); // [R12]
    end
  end

  // byte program strobe toward the array; ignored during erase
  always_ff @(posedge clock) begin
    if (rst) begin
      prog_wr   <= 1'b0;
      prog_col  <= '0;
      prog_data <= '0;
    end else begin
      prog_wr <= io_flash_wr && (state_r == FPEC_IDLE || state_r == FPEC_ROW);
      if (io_flash_wr) begin
        prog_col  <= (state_r == FPEC_ROW) ? inc_r : col_r; // [R2] [R12]
        prog_data <= io_flash_data;
      end
    end
  end

  assign erase_mass     = state_r == FPEC_MASS; // [R7]
  assign erase_page     = state_r == FPEC_PAGE; // [R8]
  assign erase_page_sel = page_r;

  // cpu wait: only flash targets are held
  always_comb begin
    cpu_wait = 1'b0;
    if (cpu_req && cpu_in_flash) begin
      if (erase_mass || erase_page) begin
        cpu_wait = 1'b1; // [R9]
      end else if (state_r == FPEC_ROW && !cpu_we) begin
        cpu_wait = 1'b1; // [R11]
      end
    end
  end // outside flash cpu_wait stays low [R10]

  // interrupt status: set beats write-one clear
  assign ev[`FPEC_ST_ERASE] = (state_r == FPEC_MASS || state_r == FPEC_PAGE) && tif.done;
  assign ev[`FPEC_ST_ROW]   = row_last;
  assign ev[`FPEC_ST_TMO]   = state_r == FPEC_ROW && tif.done && !row_last;

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_r <= '0;
    end else if (reg_wr && hit(reg_addr, `FPEC_OFF_STAT)) begin
      stat_r <= (stat_r & ~reg_wdata[`FPEC_ST_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_r <= '0;
    end else if (reg_wr && hit(reg_addr, `FPEC_OFF_MASK)) begin
      mask_r <= reg_wdata[`FPEC_ST_W-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // control reads back the running operation, so erase bits fall at the end
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[`FPEC_CTL_MASS] = erase_mass; // [R6]
    ctl_view[`FPEC_CTL_PAGE] = erase_page; // [R6]
    ctl_view[`FPEC_CTL_ROW]  = state_r == FPEC_ROW;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FPEC_OFF_COL:  reg_rdata <= {1'b0, col_r}; // [R4]
        `FPEC_OFF_CTL:  reg_rdata <= ctl_view;
        `FPEC_OFF_PAGE: reg_rdata <= {1'b0, page_r};
        `FPEC_OFF_STAT: reg_rdata <= {5'h00, stat_r};
        `FPEC_OFF_MASK: reg_rdata <= {5'h00, mask_r};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_col_bit7_zero: assert property (reg_rd && reg_addr == `FPEC_OFF_COL |=> !reg_rdata[7]) // [R4]
    else $error("column read shows bit 7 set");
  a_col_store: assert property (wr_col |=> col_r == $past(reg_wdata[6:0])) // [R1]
    else $error("column write not stored");
  a_single_col: assert property (io_flash_wr && state_r == FPEC_IDLE |=> prog_wr && prog_col == $past(col_r)) // [R2]
    else $error("single write used wrong column");
  a_row_seed: assert property (wr_ctl && reg_wdata == 8'h04 |=> state_r == FPEC_ROW && inc_r == $past(col_r)) // [R3]
    else $error("incrementer not seeded from column");
  a_row_step: assert property (state_r == FPEC_ROW && io_flash_wr |=> inc_r == $past(inc_r) + 7'h01) // [R12]
    else $error("incrementer did not step");
  a_mass_start: assert property (wr_ctl && reg_wdata[1] |=> erase_mass && ctl_view[1]) // [R5]
    else $error("mass erase not launched");
  a_erase_clear: assert property (erase_page && tif.done |=> !erase_page && !ctl_view[0]) // [R6]
    else $error("page erase bit did not clear");
  a_page_len: assert property ($rose(erase_page) |-> erase_page [*8]) // [R8]
    else $error("page erase ended early");
  a_erase_wait: assert property ((erase_mass || erase_page) && cpu_req && cpu_in_flash |-> cpu_wait) // [R9]
    else $error("flash access not held during erase");
  a_nonflash_go: assert property (cpu_req && !cpu_in_flash |-> !cpu_wait) // [R10]
    else $error("non-flash access stalled");
  a_row_rd_wait: assert property (state_r == FPEC_ROW && cpu_req && cpu_in_flash && !cpu_we |-> cpu_wait) // [R11]
    else $error("flash read not held during row program");
  a_row_end: assert property (row_last |=> state_r == FPEC_IDLE && stat_r[1]) // [R11]
    else $error("row did not finish at last column");

  c_mass_done: cover property (erase_mass && tif.done);
  c_row_full: cover property (row_last);
  c_row_tmo: cover property (state_r == FPEC_ROW && tif.done);
  c_irq: cover property (irq);
endmodule // fpec_top
